/* File: gpt_pkg.sv */
// constants, field layouts and shared types of the 16-bit general-purpose timer block
// assumes one core clock; source clocks other than the bus clock arrive as one-cycle enables
package gpt_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int ADDR_W = 12; // 1 KB window per timer plus the interrupt block
	localparam int DATA_W = 32; // register bus data width
	localparam int CNT_W = 16; // counter width
	localparam int PRE_W = 15; // prescaler counter width, enough for 32768
	localparam int NUM_UNITS = 3; // identical timer units
	localparam int NUM_SRC = 4; // selectable count sources

	////////////////////////////////////////////////////////////////////////////////
	// address map: addr[11:10] picks the unit, addr[9:0] the register
	localparam logic [1:0] BLK_IRQ = 2'h3; // block index of the shared interrupt registers
	localparam logic [9:0] OFS_RELOAD = 10'h000; // reload_value_reg
	localparam logic [9:0] OFS_COUNT = 10'h004; // current_count_reg
	localparam logic [9:0] OFS_SETUP = 10'h008; // timer_setup_reg
	localparam logic [9:0] OFS_ACK = 10'h00C; // timeout_ack_reg
	localparam logic [9:0] OFS_FLAGS = 10'h01C; // timer_flags_reg
	localparam logic [9:0] OFS_IRQ_STAT = 10'h000; // sticky timeout events, write one to clear
	localparam logic [9:0] OFS_IRQ_MASK = 10'h004; // interrupt mask, one enables

	////////////////////////////////////////////////////////////////////////////////
	// timer_setup_reg fields
	localparam int SETUP_W = 8;
	localparam int SETUP_RLD = 7; // clear also reloads the counter
	localparam int SETUP_CLK_HI = 6; // clock select, upper bit
	localparam int SETUP_CLK_LO = 5; // clock select, lower bit
	localparam int SETUP_EN = 4; // timer enable
	localparam int SETUP_PERIODIC = 3; // periodic_select
	localparam int SETUP_UP = 2; // count direction, one counts up
	localparam int SETUP_PRE_HI = 1; // prescaler code, upper bit
	localparam logic [SETUP_W-1:0] SETUP_RST = 8'h0A; // periodic, count down, divide by 256
	localparam int ACK_TMOUT = 0; // timeout_ack_reg clear bit
	localparam int FLAG_TMOUT = 0; // timer_flags_reg timeout bit

	////////////////////////////////////////////////////////////////////////////////
	// counter scale and reset values
	localparam logic [CNT_W-1:0] FULL_SCALE = 16'hFFFF;
	localparam logic [CNT_W-1:0] ZERO_SCALE = 16'h0000;
	localparam logic [CNT_W-1:0] ONE_STEP = 16'h0001;
	localparam logic [CNT_W-1:0] RELOAD_RST = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// clock sources and prescaler terminal counts (division factor minus one)
	localparam logic [1:0] SRC_PERIPH = 2'h0; // peripheral_bus_clock, every core cycle
	localparam logic [1:0] SRC_CORE = 2'h1; // core_clock
	localparam logic [1:0] SRC_LFOSC = 2'h2; // 32 kHz oscillator
	localparam logic [1:0] SRC_ANALOG = 2'h3; // analog root clock
	localparam logic [PRE_W-1:0] DIV_LAST_1 = 15'h0000;
	localparam logic [PRE_W-1:0] DIV_LAST_4 = 15'h0003;
	localparam logic [PRE_W-1:0] DIV_LAST_16 = 15'h000F;
	localparam logic [PRE_W-1:0] DIV_LAST_256 = 15'h00FF;
	localparam logic [PRE_W-1:0] DIV_LAST_32768 = 15'h7FFF;

	// per-unit software-visible state
	typedef struct packed {
		logic [CNT_W-1:0] reload; // reload value
		logic [CNT_W-1:0] count; // live counter
		logic [SETUP_W-1:0] setup; // control fields
		logic tmout; // timeout flag, also the unit's interrupt
	} gpt_unit_t;

	// last prescaler count for a code; code 00 divides by 4 only on the fast sources
	function automatic logic [PRE_W-1:0] gpt_div_last(input logic [1:0] code, input logic fast);
		logic [PRE_W-1:0] last;
		last = DIV_LAST_32768;
		case (code)
			2'h0: last = fast ? DIV_LAST_4 : DIV_LAST_1;
			2'h1: last = DIV_LAST_16;
			2'h2: last = DIV_LAST_256;
			default: last = DIV_LAST_32768;
		endcase
		return last;
	endfunction : gpt_div_last

	// value the counter starts from on enable or on a reload
	function automatic logic [CNT_W-1:0] gpt_start_value(input logic [SETUP_W-1:0] setup,
		input logic [CNT_W-1:0] reload);
		logic [CNT_W-1:0] start;
		start = reload;
		if (!setup[SETUP_PERIODIC])
			start = setup[SETUP_UP] ? ZERO_SCALE : FULL_SCALE;
		return start;
	endfunction : gpt_start_value

endpackage : gpt_pkg

/* File: gpt_tick_if.sv */
// link between a timer unit and its prescaler
// assumes both ends run on the same core clock
interface gpt_tick_if;
	logic srcEn; // selected source edge, one-cycle pulse
	logic fastSrc; // bus or core clock selected
	logic [1:0] preCode; // prescaler code
	logic run; // timer enabled; low clears the prescaler
	logic tick; // prescaled count step, one-cycle pulse

	// timer side drives the controls, takes the tick
	modport unit (output srcEn, output fastSrc, output preCode, output run, input tick);
	// prescaler side
	modport pre (input srcEn, input fastSrc, input preCode, input run, output tick);
endinterface : gpt_tick_if

/* File: gpt_prescaler.sv */
// prescaler of one timer unit: divides the selected source enable down to count steps
// assumes srcEn is already synchronous to core_clk
module gpt_prescaler
	import gpt_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// unit link
	gpt_tick_if.pre lnk
);

	// all prescaler state
	typedef struct packed {
		logic [PRE_W-1:0] cnt; // source edges seen in this period
		logic tick; // registered step
	} gpt_pre_state_t;

	gpt_pre_state_t state_ff; // registered state
	gpt_pre_state_t nxt_state; // next state
	logic [PRE_W-1:0] lastCnt; // terminal count for the current code

	assign lastCnt = gpt_div_last(lnk.preCode, lnk.fastSrc);
	assign lnk.tick = state_ff.tick;

	////////////////////////////////////////////////////////////////////////////////
	// next state: count source edges, emit one tick per full period
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.tick = 1'b0;
		if (!lnk.run)
		begin
			// disabled: restart the period so the first step is a whole one
			nxt_state.cnt = '0;
		end
		else if (lnk.srcEn)
		begin
			if (state_ff.cnt >= lastCnt)
			begin
				// period complete
				nxt_state.cnt = '0;
				nxt_state.tick = 1'b1;
			end
			else
			begin
				nxt_state.cnt = state_ff.cnt + 15'h0001;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (reset)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_tick_needs_run: assert property (@(posedge core_clk) disable iff (reset)
		lnk.tick |-> $past(lnk.run) && $past(lnk.srcEn))
		else $error("prescaler ticked without an enabled source edge");
	a_fast_div_four: assert property (@(posedge core_clk) disable iff (reset)
		(lnk.run && lnk.srcEn && lnk.fastSrc && lnk.preCode == 2'h0) [*4] |-> ##1 $past(lnk.tick, 3)
		|| $past(lnk.tick, 2) || $past(lnk.tick, 1) || lnk.tick)
		else $error("fast source code 00 does not divide by four");

endmodule : gpt_prescaler

/* File: gpt_timer.sv */
// three 16-bit up/down timers with register port and shared interrupt
// assumes srcTick pulses are synchronous one-cycle enables on core_clk
//
// Summary of operation
// - three units, 16-bit counter, up or down
// - four selectable count sources per unit
// - prescaler divides by 1, 4, 16, 256, 32768
// - code 00 divides by 4 on fast sources
// - full scale all ones, zero scale zero
// - free-run sweeps range, restarts on step to end
// - bit 2 direction; periodic runs from reload
// - direction one counts up, zero counts down
// - periodic end: interrupt, reload, keep counting
// - reaching end sets timeout flag and interrupt
// - writing ack bit 0 clears flag, interrupt
// - reload bit makes ack also reload counter
// - count readable anytime without stopping timer
// - down periodic period is reload times prescale
// - clearing enable stops and zeroes the counter
//
// Added by the designer: the strobed register port and the register offsets.
module gpt_timer
	import gpt_pkg::*;
#(
	parameter int UNITS = NUM_UNITS // number of identical units
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire logic [gpt_pkg::ADDR_W-1:0] regAddr,
	input wire logic [gpt_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [gpt_pkg::DATA_W-1:0] regRdData,
	// source enables: core clock, 32 kHz oscillator, analog root clock
	input wire logic [gpt_pkg::NUM_SRC-2:0] srcTick,
	// interrupts
	output logic [UNITS-1:0] unitIrq,
	output logic timeoutIrq
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	// all block state
	typedef struct packed {
		gpt_unit_t [UNITS-1:0] unit; // per-unit registers and counters
		logic [UNITS-1:0] irqStat; // sticky timeout events
		logic [UNITS-1:0] irqMask; // interrupt mask
		logic irq; // registered interrupt line
		logic [DATA_W-1:0] rdData; // registered read answer
	} gpt_state_t;

	gpt_state_t state_ff; // registered state
	gpt_state_t nxt_state; // next state
	logic [UNITS-1:0] unitTick; // prescaled steps, one per unit
	logic [NUM_SRC-1:0] srcAll; // all four source enables
	logic [1:0] blkSel; // addressed block
	logic [9:0] regOfs; // offset within the block

	// bus clock source runs every core cycle
	assign srcAll = {srcTick, 1'b1};
	assign blkSel = regAddr[ADDR_W-1:ADDR_W-2];
	assign regOfs = regAddr[9:0];

	////////////////////////////////////////////////////////////////////////////////
	// one prescaler per unit
	genvar gi;
	generate
		for (gi = 0; gi < UNITS; gi++)
		begin : g_pre
			gpt_tick_if lnk ();
			logic [1:0] clkSel; // selected source of this unit
			assign clkSel = state_ff.unit[gi].setup[SETUP_CLK_HI:SETUP_CLK_LO];
			assign lnk.srcEn = srcAll[clkSel];
			assign lnk.fastSrc = (clkSel == SRC_PERIPH) || (clkSel == SRC_CORE);
			assign lnk.preCode = state_ff.unit[gi].setup[SETUP_PRE_HI:0];
			assign lnk.run = state_ff.unit[gi].setup[SETUP_EN];
			assign unitTick[gi] = lnk.tick;
			gpt_prescaler u_pre (
				.core_clk(core_clk),
				.reset(reset),
				.lnk(lnk.pre)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// next state: counting, timeouts, register writes and reads
	always_comb
	begin
		gpt_unit_t u;
		logic hit;
		logic [CNT_W-1:0] endVal;
		logic [CNT_W-1:0] stepVal;
		logic wrHere;
		logic [DATA_W-1:0] rdVal;
		logic [UNITS-1:0] hitAll; // timeouts of this cycle, kept for the status clear
		u = '0;
		hit = 1'b0;
		hitAll = '0;
		endVal = ZERO_SCALE;
		stepVal = ZERO_SCALE;
		wrHere = 1'b0;
		rdVal = '0;
		nxt_state = state_ff;
		for (int i = 0; i < UNITS; i++)
		begin
			u = state_ff.unit[i];
			wrHere = regWr && (blkSel == 2'(i));
			// end of range and the counter value one step on in the chosen direction
			endVal = u.setup[SETUP_UP] ? FULL_SCALE : ZERO_SCALE;
			stepVal = u.setup[SETUP_UP] ? (u.count + ONE_STEP) : (u.count - ONE_STEP);
			// the step that lands on the end restarts at once, so a down count
			// from the reload value times out after exactly that many steps
			hit = u.setup[SETUP_EN] && unitTick[i] && (stepVal == endVal || u.count == endVal);
			hitAll[i] = hit;
			if (!u.setup[SETUP_EN])
			begin
				// disabled: counter held at its reset value
				nxt_state.unit[i].count = ZERO_SCALE;
			end
			else if (hit)
			begin
				// restart from reload in periodic mode, else from the far end
				nxt_state.unit[i].count = gpt_start_value(u.setup, u.reload);
				nxt_state.unit[i].tmout = 1'b1;
				nxt_state.irqStat[i] = 1'b1;
			end
			else if (unitTick[i])
			begin
				// one step per prescaled tick in the chosen direction
				nxt_state.unit[i].count = stepVal;
			end
			// software writes
			if (wrHere && regOfs == OFS_RELOAD)
				nxt_state.unit[i].reload = regWrData[CNT_W-1:0];
			if (wrHere && regOfs == OFS_SETUP)
			begin
				nxt_state.unit[i].setup = regWrData[SETUP_W-1:0];
				// enabling loads the start point of the selected mode
				if (regWrData[SETUP_EN] && !u.setup[SETUP_EN])
					nxt_state.unit[i].count = gpt_start_value(regWrData[SETUP_W-1:0],
						u.reload);
				if (!regWrData[SETUP_EN])
					nxt_state.unit[i].count = ZERO_SCALE;
			end
			if (wrHere && regOfs == OFS_ACK && regWrData[ACK_TMOUT])
			begin
				// a timeout in the same cycle is kept: set wins over clear
				nxt_state.unit[i].tmout = hit;
				nxt_state.irqStat[i] = hit;
				if (u.setup[SETUP_RLD] && u.setup[SETUP_EN])
					nxt_state.unit[i].count = gpt_start_value(u.setup, u.reload);
			end
		end
		// shared interrupt registers
		if (regWr && blkSel == BLK_IRQ && regOfs == OFS_IRQ_STAT)
		begin
			for (int i = 0; i < UNITS; i++)
			begin
				// only a timeout in this very cycle survives the clear: set wins
				if (regWrData[i] && !hitAll[i])
					nxt_state.irqStat[i] = 1'b0;
			end
		end
		if (regWr && blkSel == BLK_IRQ && regOfs == OFS_IRQ_MASK)
			nxt_state.irqMask = regWrData[UNITS-1:0];
		nxt_state.irq = |(nxt_state.irqStat & nxt_state.irqMask);
		// read answer, valid the cycle after the strobe only
		rdVal = '0;
		if (blkSel == BLK_IRQ)
		begin
			if (regOfs == OFS_IRQ_STAT)
				rdVal[UNITS-1:0] = state_ff.irqStat;
			else if (regOfs == OFS_IRQ_MASK)
				rdVal[UNITS-1:0] = state_ff.irqMask;
		end
		else if (32'(blkSel) < UNITS)
		begin
			u = state_ff.unit[blkSel];
			case (regOfs)
				OFS_RELOAD: rdVal[CNT_W-1:0] = u.reload;
				OFS_COUNT: rdVal[CNT_W-1:0] = u.count;
				OFS_SETUP: rdVal[SETUP_W-1:0] = u.setup;
				OFS_FLAGS: rdVal[FLAG_TMOUT] = u.tmout;
				default: rdVal = '0; // ack register and holes read zero
			endcase
		end
		nxt_state.rdData = regRd ? rdVal : '0;
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_ff <= '0;
			for (int i = 0; i < UNITS; i++)
			begin
				state_ff.unit[i].setup <= SETUP_RST;
				state_ff.unit[i].reload <= RELOAD_RST;
			end
		end
		else
			state_ff <= nxt_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign regRdData = state_ff.rdData;
	assign timeoutIrq = state_ff.irq;
	generate
		for (gi = 0; gi < UNITS; gi++)
		begin : g_irq
			assign unitIrq[gi] = state_ff.unit[gi].tmout;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// checks on unit 0
	logic [CNT_W-1:0] c0; // unit 0 counter
	logic en0; // unit 0 enabled
	logic up0; // unit 0 counts up
	logic per0; // unit 0 periodic
	assign c0 = state_ff.unit[0].count;
	assign en0 = state_ff.unit[0].setup[SETUP_EN];
	assign up0 = state_ff.unit[0].setup[SETUP_UP];
	assign per0 = state_ff.unit[0].setup[SETUP_PERIODIC];

	a_disabled_zero: assert property (@(posedge core_clk) disable iff (reset)
		!en0 && !regWr |=> c0 == ZERO_SCALE)
		else $error("disabled counter not at zero");
	a_hold_no_tick: assert property (@(posedge core_clk) disable iff (reset)
		en0 && !unitTick[0] && !regWr |=> c0 == $past(c0))
		else $error("counter moved without a tick");
	a_step_up: assert property (@(posedge core_clk) disable iff (reset)
		en0 && up0 && unitTick[0] && !regWr && c0 < 16'hFFFE |=> c0 == $past(c0) + ONE_STEP)
		else $error("up count did not step by one");
	a_step_down: assert property (@(posedge core_clk) disable iff (reset)
		en0 && !up0 && unitTick[0] && !regWr && c0 > 16'h0001 |=> c0 == $past(c0) - ONE_STEP)
		else $error("down count did not step by one");
	a_periodic_reload: assert property (@(posedge core_clk) disable iff (reset)
		en0 && per0 && !up0 && unitTick[0] && !regWr && c0 == ONE_STEP
		|=> c0 == state_ff.unit[0].reload && state_ff.unit[0].tmout && unitIrq[0])
		else $error("periodic timeout did not reload and flag");
	a_freerun_wrap: assert property (@(posedge core_clk) disable iff (reset)
		en0 && !per0 && up0 && unitTick[0] && !regWr && c0 == 16'hFFFE |=> c0 == ZERO_SCALE)
		else $error("free-run up count did not restart at zero");
	a_ack_clears: assert property (@(posedge core_clk) disable iff (reset)
		regWr && blkSel == 2'h0 && regOfs == OFS_ACK && regWrData[ACK_TMOUT] && !unitTick[0]
		|=> !unitIrq[0] && !state_ff.irqStat[0])
		else $error("ack did not clear the timeout");
	a_ack_reload: assert property (@(posedge core_clk) disable iff (reset)
		regWr && blkSel == 2'h0 && regOfs == OFS_ACK && regWrData[ACK_TMOUT] && en0
		&& state_ff.unit[0].setup[SETUP_RLD] && per0 |=> c0 == $past(state_ff.unit[0].reload))
		else $error("ack with reload bit did not reload");
	a_read_count: assert property (@(posedge core_clk) disable iff (reset)
		regRd && blkSel == 2'h0 && regOfs == OFS_COUNT |=> regRdData == 32'($past(c0)))
		else $error("count read mismatch");
	a_irq_level: assert property (@(posedge core_clk) disable iff (reset)
		$rose(state_ff.irqStat[0]) && state_ff.irqMask[0] |-> timeoutIrq)
		else $error("unmasked timeout did not raise the interrupt");

endmodule : gpt_timer

/* File: gpt_timer_tb.sv */
// self-checking bench of the three-unit 16-bit timer block and its register port
// assumes gpt_pkg and the timer design are compiled first; one 100 MHz core clock
`define CHK(nm, exp, got) \
	begin \
		checksDone++; \
		if ((got) !== (exp)) \
		begin \
			nMismatch++; \
			$display("MISMATCH %s expected %h seen %h", nm, exp, got); \
		end \
	end

module gpt_timer_tb;
	import gpt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////////////
	// signals
	logic coreClk; // 100 MHz
	logic reset; // synchronous, active high
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData;
	logic regWr;
	logic regRd;
	logic [DATA_W-1:0] regRdData;
	logic [NUM_SRC-2:0] srcTick; // core, slow osc, analog enables
	logic [NUM_UNITS-1:0] unitIrq;
	logic timeoutIrq;
	int cyc = 0; // free cycle count, timestamps interrupts
	int nMismatch = 0;
	int checksDone = 0;
	logic [DATA_W-1:0] rdv; // last read word
	int t0;
	int t1;

	// register row: optional write, then a read of the same place
	typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e;} gpt_reg_row_t;
	// period row: unit, setup word, reload value, cycles between timeouts
	typedef struct {logic [1:0] u; logic [7:0] s; logic [15:0] ld; int per;} gpt_per_row_t;

	gpt_reg_row_t regRows [12] = '{
		'{12'h000, 1'b0, 32'h0, 32'h0}, // reload after reset
		'{12'h404, 1'b0, 32'h0, 32'h0}, // count after reset
		'{12'h808, 1'b0, 32'h0, 32'h0A}, // setup after reset
		'{12'h00C, 1'b0, 32'h0, 32'h0}, // ack reads zero
		'{12'h41C, 1'b0, 32'h0, 32'h0}, // flags after reset
		'{12'hC00, 1'b0, 32'h0, 32'h0}, // status after reset
		'{12'hC04, 1'b0, 32'h0, 32'h0}, // mask after reset
		'{12'h800, 1'b1, 32'hABCD1234, 32'h1234}, // upper bits dropped
		'{12'h008, 1'b1, 32'hFFFFFF07, 32'h07}, // setup is eight bits
		'{12'h404, 1'b1, 32'h5555, 32'h0}, // count is read only
		'{12'h010, 1'b1, 32'h1, 32'h0}, // unmapped offset
		'{12'hC04, 1'b1, 32'h5, 32'h5} // mask read back
	};

	// one row per source and prescaler code; rates of srcTick set the factors
	gpt_per_row_t perRows [6] = '{
		'{2'h0, 8'h18, 16'h0003, 12}, // bus clock, divide by 4
		'{2'h1, 8'h38, 16'h0002, 8}, // core clock, divide by 4
		'{2'h2, 8'h7C, 16'hFFFA, 15}, // analog, divide by 1, counting up
		'{2'h0, 8'h59, 16'h0005, 160}, // slow osc, divide by 16
		'{2'h1, 8'h1A, 16'h0002, 512}, // divide by 256
		'{2'h2, 8'h1B, 16'h0001, 32768} // divide by 32768
	};

	////////////////////////////////////////////////////////////////////////////////
	// design
	gpt_timer dut (
		.core_clk(coreClk),
		.reset(reset),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.regRdData(regRdData),
		.srcTick(srcTick),
		.unitIrq(unitIrq),
		.timeoutIrq(timeoutIrq)
	);

	// clock
	initial
	begin
		coreClk = 1'b0;
		forever #5 coreClk = ~coreClk;
	end

	// source enables: core every cycle, slow osc every 2nd, analog every 3rd
	always @(posedge coreClk)
	begin
		cyc <= cyc + 1;
		srcTick <= {cyc % 3 == 0, cyc % 2 == 0, 1'b1};
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus tasks; each starts on the next edge so strobes never merge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge coreClk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge coreClk);
		regWr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a);
		@(posedge coreClk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge coreClk);
		regRd <= 0;
		#1 rdv = regRdData;
	endtask : rd

	// bounded wait for a unit's timeout; stamps the first cycle it is seen
	task automatic wait_irq(input int u, output int t);
		int n;
		n = 0;
		do
		begin
			@(posedge coreClk);
			#1 n++;
		end
		while (n < 40000 && unitIrq[u] !== 1'b1);
		t = cyc;
		`CHK("unitIrq", 1'b1, unitIrq[u])
	endtask : wait_irq

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// the longest row needs two 32768-cycle periods; this leaves some margin
	initial
	begin
		#950000;
		nMismatch++;
		$display("watchdog expired");
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		reset = 1'b1;
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
		srcTick = '0;
		repeat (4) @(posedge coreClk);
		reset <= 1'b0;
		// register rows
		foreach (regRows[i])
		begin
			if (regRows[i].w)
				wr(regRows[i].a, regRows[i].d);
			rd(regRows[i].a);
			`CHK("register", regRows[i].e, rdv)
		end
		$display("test registers done");
		// period rows: second timeout measured from the first
		foreach (perRows[i])
		begin
			wr({perRows[i].u, OFS_RELOAD}, {16'h0, perRows[i].ld});
			wr({perRows[i].u, OFS_SETUP}, {24'h0, perRows[i].s});
			wait_irq(perRows[i].u, t0);
			wr({perRows[i].u, OFS_ACK}, 32'h1);
			@(posedge coreClk);
			#1 `CHK("ack", 1'b0, unitIrq[perRows[i].u])
			wait_irq(perRows[i].u, t1);
			`CHK("period", perRows[i].per, t1 - t0)
			rd({perRows[i].u, OFS_FLAGS});
			`CHK("flags", 32'h1, rdv)
			wr({perRows[i].u, OFS_SETUP}, {24'h0, perRows[i].s & 8'hEF});
			rd({perRows[i].u, OFS_COUNT});
			`CHK("stopped count", 32'h0, rdv)
			wr({perRows[i].u, OFS_ACK}, 32'h1);
		end
		$display("test periods done");
		// interrupt status, mask and clear
		wr(12'hC00, 32'h7);
		wr(12'hC04, 32'h0);
		wr(12'h000, 32'h40);
		wr(12'h008, 32'h18);
		wait_irq(0, t0);
		rd(12'hC00);
		`CHK("status", 1'b1, rdv[0])
		`CHK("masked", 1'b0, timeoutIrq)
		wr(12'hC04, 32'h1);
		@(posedge coreClk);
		#1 `CHK("unmasked", 1'b1, timeoutIrq)
		wr(12'hC00, 32'h1);
		@(posedge coreClk);
		#1 `CHK("status cleared", 1'b0, timeoutIrq)
		`CHK("flag kept", 1'b1, unitIrq[0])
		wr(12'h00C, 32'h1);
		@(posedge coreClk);
		#1 `CHK("flag cleared", 1'b0, unitIrq[0])
		$display("test interrupt done");
		// live count and reload on ack; a stale count would not move
		wr(12'h008, 32'h08);
		wr(12'h000, 32'h100);
		wr(12'h008, 32'h98);
		repeat (20) @(posedge coreClk);
		rd(12'h004);
		t0 = int'(rdv);
		// ticks come every fourth cycle; wait long enough for at least one
		repeat (4) @(posedge coreClk);
		rd(12'h004);
		`CHK("count moves", 1'b1, rdv < t0 && rdv > 32'hF0)
		wr(12'h000, 32'h200);
		wr(12'h00C, 32'h1);
		rd(12'h004);
		`CHK("reload on ack", 1'b1, rdv >= 32'h1FE && rdv <= 32'h200)
		$display("test reload done");
		// free running start values
		wr(12'h408, 32'h13);
		rd(12'h404);
		`CHK("free down start", FULL_SCALE, rdv[15:0])
		wr(12'h408, 32'h03);
		rd(12'h404);
		`CHK("disabled count", ZERO_SCALE, rdv[15:0])
		wr(12'h408, 32'h13);
		// second reset while running
		@(posedge coreClk);
		reset <= 1'b1;
		repeat (2) @(posedge coreClk);
		reset <= 1'b0;
		rd(12'h404);
		`CHK("count after reset", 32'h0, rdv)
		rd(12'h408);
		`CHK("setup after reset", 32'h0A, rdv)
		`CHK("irq after reset", 3'h0, unitIrq)
		$display("test free run and reset done");
		wrap_up();
	end

endmodule : gpt_timer_tb
